//--- hw/ulp_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module ulp_baud_gen
(
  input wire logic     clk,
  input wire logic     nrst,
  ulp_baud_if.gen      bif
);
  import ulp_pkg::*;

  logic [BAUD_CNT_W-1:0] cnt_r;
  logic [BAUD_CNT_W-1:0] cnt_nxt;
  logic [DIV_W-1:0]      div_seen_r;
  logic                  tick_r;
  logic                  tick_nxt;
  logic                  run_r;

  wire                  div_zero = (bif.divisor == '0);
  wire                  div_chg  = (bif.divisor != div_seen_r);
  wire [BAUD_CNT_W-1:0] period_m1 = {bif.divisor, 4'h0} - 20'h00001;

  // Period is sixteen times the divisor; zero stops the clock.
  assign cnt_nxt  = (div_zero || div_chg || cnt_r == '0) ? period_m1 : cnt_r - 20'h00001; // (R4)
  assign tick_nxt = !div_zero && !div_chg && (cnt_r == '0); // (R4) (R7)

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r      <= '0;
      div_seen_r <= '0;
      tick_r     <= 1'b0;
      run_r      <= 1'b0;
    end
    else
    begin
      cnt_r      <= cnt_nxt;
      div_seen_r <= bif.divisor;
      tick_r     <= tick_nxt;
      run_r      <= !div_zero; // (R7)
    end
  end

  assign bif.tick    = tick_r;
  assign bif.running = run_r;
endmodule
`default_nettype wire

//--- hw/ulp_baud_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ulp_baud_if;
  import ulp_pkg::*;

  logic [DIV_W-1:0] divisor;
  logic             tick;
  logic             running;

  modport gen
  (
    input  divisor,
    output tick,
    output running
  );

  modport user
  (
    output divisor,
    input  tick,
    input  running
  );
endinterface
`default_nettype wire

//--- hw/ulp_pkg.sv
package ulp_pkg;

  // ************************************************************
  // Bus geometry.
  // ************************************************************
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DIV_W  = 16;

  // ************************************************************
  // Register byte addresses.
  // ************************************************************
  localparam logic [ADDR_W-1:0] SCRATCH_OFS  = 32'h5000111C;
  localparam logic [ADDR_W-1:0] LP_DIV_LO_OFS = 32'h50001120;
  localparam logic [ADDR_W-1:0] LP_DIV_HI_OFS = 32'h50001124;
  localparam logic [ADDR_W-1:0] LINE_CTRL_OFS = 32'h50001128;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 32'h5000112C;

  // ************************************************************
  // Field positions and reset values.
  // ************************************************************
  localparam int unsigned DIVISOR_LATCH_ACCESS_BIT_BIT       = 7;
  localparam int unsigned STAT_CLK_ON    = 0;
  localparam int unsigned STAT_PULSE_LO  = 8;
  localparam logic [BYTE_W-1:0] SCRATCH_RST   = 8'h00;
  localparam logic [BYTE_W-1:0] LP_DIV_RST    = 8'h00;
  localparam logic [BYTE_W-1:0] LINE_CTRL_RST = 8'h00;

  // ************************************************************
  // Baud clock geometry.
  // ************************************************************
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned BAUD_CNT_W = DIV_W + 4;

endpackage

//--- hw/ulp_top.sv
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// (R1) An 8-bit scratch byte stores software data and affects nothing else.
// (R2) Two byte registers form the 16-bit low-power divisor, low and high.
// (R3) Both divisor bytes are reachable only while line control bit 7 is set.
// (R4) Low-power baud clock runs at clock divided by sixteen times divisor.
// (R5) Software picks a divisor giving a 115.2K low-power baud rate.
// (R6) Receiver uses the low-power clock to detect minimum-width infrared pulses.
// (R7) A zero divisor stops the low-power clock and all pulse detection.
// (R8) Software waits eight slowest-clock cycles after a divisor write before traffic.
// (R9) Bits 15 to 8 of the three registers read zero, writes ignored.
module ulp_top
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [ulp_pkg::ADDR_W-1:0] address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [ulp_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]             byteenable,
  output var  logic [ulp_pkg::DATA_W-1:0] readdata,
  output var  logic                   waitrequest,
  input  wire logic                   sir_in,
  output var  logic                   lp_pulse,
  output var  logic                   lp_clk_on
);
  import ulp_pkg::*;

  // ************************************************************
  // Register state.
  // ************************************************************
  logic [BYTE_W-1:0] scratch_byte_r;
  logic [BYTE_W-1:0] lp_div_lo_r;
  logic [BYTE_W-1:0] lp_div_hi_r;
  logic [BYTE_W-1:0] line_ctrl_r;
  logic [BYTE_W-1:0] pulse_cnt_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              wait_r;

  // ************************************************************
  // Input synchroniser and pulse tracking.
  // ************************************************************
  logic sir_s1_r;
  logic sir_s2_r;
  logic sir_d_r;
  logic seen_tick_r;
  logic pulse_r;

  ulp_baud_if bif ();

  ulp_baud_gen u_gen
  (
    .clk  (clk),
    .nrst (nrst),
    .bif  (bif.gen)
  );

  assign bif.divisor = {lp_div_hi_r, lp_div_lo_r}; // (R2)

  // ************************************************************
  // Bus decode.
  // ************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire divisor_latch_access_bit      = line_ctrl_r[DIVISOR_LATCH_ACCESS_BIT_BIT];
  wire req       = read || write;
  wire accept    = req && !wait_r;
  wire wr_lane0  = accept && write && byteenable[0];
  wire sel_scr   = hit(address, SCRATCH_OFS);
  wire sel_lo    = hit(address, LP_DIV_LO_OFS) && divisor_latch_access_bit; // (R3)
  wire sel_hi    = hit(address, LP_DIV_HI_OFS) && divisor_latch_access_bit; // (R3)
  wire sel_lcr   = hit(address, LINE_CTRL_OFS);
  wire sel_stat  = hit(address, STATUS_OFS);
  wire [DATA_W-1:0] stat_word =
    {16'h0000, pulse_cnt_r, 7'h00, bif.running};

  // Bits 31 to 8 of every byte register read zero.
  assign rdata_nxt =
    sel_scr  ? {24'h000000, scratch_byte_r} : // (R1) (R9)
    sel_lo   ? {24'h000000, lp_div_lo_r} :    // (R9)
    sel_hi   ? {24'h000000, lp_div_hi_r} :    // (R9)
    sel_lcr  ? {24'h000000, line_ctrl_r} :
    sel_stat ? stat_word : '0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wait_r <= 1'b1;
    else
      wait_r <= !(req && wait_r);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= '0;
    else if (read && wait_r)
      rdata_r <= rdata_nxt;
  end

  // Only the low byte lane is stored; upper bits are dropped.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scratch_byte_r <= SCRATCH_RST;
      lp_div_lo_r    <= LP_DIV_RST;
      lp_div_hi_r    <= LP_DIV_RST;
      line_ctrl_r    <= LINE_CTRL_RST;
    end
    else if (wr_lane0)
    begin
      if (sel_scr)
        scratch_byte_r <= writedata[BYTE_W-1:0]; // (R1) (R9)
      if (sel_lo)
        lp_div_lo_r <= writedata[BYTE_W-1:0]; // (R2) (R3) (R9)
      if (sel_hi)
        lp_div_hi_r <= writedata[BYTE_W-1:0]; // (R2) (R3) (R9)
      if (sel_lcr)
        line_ctrl_r <= writedata[BYTE_W-1:0];
    end
  end

  // ************************************************************
  // Minimum-width pulse detection.
  // ************************************************************
  wire sir_fall  = !sir_s2_r && sir_d_r;
  wire pulse_ok  = sir_fall && seen_tick_r && bif.running; // (R6) (R7)

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sir_s1_r <= 1'b0;
      sir_s2_r <= 1'b0;
      sir_d_r  <= 1'b0;
    end
    else
    begin
      sir_s1_r <= sir_in;
      sir_s2_r <= sir_s1_r;
      sir_d_r  <= sir_s2_r;
    end
  end

  // A pulse counts only if a low-power tick fell while it was high.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      seen_tick_r <= 1'b0;
    else if (!bif.running || !sir_s2_r)
      seen_tick_r <= 1'b0; // (R7)
    else if (bif.tick)
      seen_tick_r <= 1'b1; // (R6)
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulse_r     <= 1'b0;
      pulse_cnt_r <= '0;
    end
    else
    begin
      pulse_r <= pulse_ok; // (R6)
      if (pulse_ok)
        pulse_cnt_r <= pulse_cnt_r + 8'h01;
    end
  end

  assign readdata    = rdata_r;
  assign waitrequest = wait_r;
  assign lp_pulse    = pulse_r;
  assign lp_clk_on   = bif.running;
endmodule
`default_nettype wire

//--- tb/test_uart_lowpower_divisor_scratch.sv
`timescale 1ns/10ps
`default_nettype none
module test_uart_lowpower_divisor_scratch;
  import ulp_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, fire = 1'b0;
  logic [3:0]  byteenable = 4'hF;
  logic [15:0] len = 16'h0000;
  logic [31:0] address = 32'h0, writedata = 32'h0, readdata, q;
  logic        waitrequest, sir_in, lp_pulse, lp_clk_on;
  int          err_count = 0, num_checks = 0, pulses = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (lp_pulse === 1'b1) pulses++;
  ulp_top i_dut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sir_in(sir_in), .lp_pulse(lp_pulse), .lp_clk_on(lp_clk_on));
  ulp_sir_model i_sir (.clk(clk), .fire(fire), .len(len), .sir_in(sir_in));
  task automatic final_report;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic io(input logic wr, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0)
    begin
      err_count++;
      final_report();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, exp);
    io(1'b0, a, 32'h0);
    check("readdata", q, exp);
  endtask
  task automatic shot(input logic [15:0] w);
    @(posedge clk);
    fire <= 1'b1;
    len <= w;
    @(posedge clk);
    fire <= 1'b0;
    repeat (int'(w) + 12) @(posedge clk);
  endtask
  task automatic t_scratch;
    rd(SCRATCH_OFS, 32'h0);
    io(1'b1, SCRATCH_OFS, 32'hFFFFFFA5);
    rd(SCRATCH_OFS, 32'hA5);
    byteenable <= 4'h0;
    io(1'b1, SCRATCH_OFS, 32'h5A);
    byteenable <= 4'hF;
    rd(SCRATCH_OFS, 32'hA5);
    io(1'b1, 32'h50001140, 32'hFF);
    rd(32'h50001140, 32'h0);
    check("lp_clk_on", {31'h0, lp_clk_on}, 32'h0);
  endtask
  task automatic t_lock;
    io(1'b1, LP_DIV_LO_OFS, 32'h3);
    io(1'b1, LINE_CTRL_OFS, 32'h80);
    rd(LP_DIV_LO_OFS, 32'h0);
    io(1'b1, LP_DIV_HI_OFS, 32'hFF12);
    rd(LP_DIV_HI_OFS, 32'h12);
    io(1'b1, LP_DIV_HI_OFS, 32'h0);
    io(1'b1, LP_DIV_LO_OFS, 32'h3);
    rd(LP_DIV_LO_OFS, 32'h3);
    io(1'b1, LINE_CTRL_OFS, 32'h0);
    rd(LP_DIV_LO_OFS, 32'h0);
    io(1'b1, LP_DIV_LO_OFS, 32'h0);
    io(1'b1, LINE_CTRL_OFS, 32'h80);
    rd(LP_DIV_LO_OFS, 32'h3);
  endtask
  task automatic t_baud;
    io(1'b1, LP_DIV_LO_OFS, 32'h36);
    repeat (8) @(posedge clk);
    check("lp_clk_on", {31'h0, lp_clk_on}, 32'h1);
    shot(16'h0014);
    check("pulses", pulses, 32'h0);
    shot(16'h0384);
    check("pulses", pulses, 32'h1);
    rd(STATUS_OFS, 32'h101);
  endtask
  task automatic t_zero;
    io(1'b1, LP_DIV_LO_OFS, 32'h0);
    repeat (8) @(posedge clk);
    check("lp_clk_on", {31'h0, lp_clk_on}, 32'h0);
    shot(16'h0384);
    check("pulses", pulses, 32'h1);
    rd(STATUS_OFS, 32'h100);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_scratch();
    t_lock();
    t_baud();
    t_zero();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire

//--- tb/ulp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ulp_monitor
  import ulp_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [31:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        sir_in,
  input wire logic        lp_pulse,
  input wire logic        lp_clk_on
);
  logic divisor_latch_access_bit_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      divisor_latch_access_bit_r <= 1'b0;
    else if (write && !waitrequest && byteenable[0] && address == LINE_CTRL_OFS)
      divisor_latch_access_bit_r <= writedata[DIVISOR_LATCH_ACCESS_BIT_BIT];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_rd;
    read && !waitrequest;
  endsequence
  chk_bus_answer: assert property (s_req |=> !waitrequest) else $error("Late.");
  chk_wait_one: assert property (!waitrequest |=> waitrequest) else $error("Wait.");
  chk_upper_zero: assert property ((s_rd and (address != STATUS_OFS)) |->
    readdata[31:8] == 24'h000000) else $error("Upper.");
  chk_lock_zero: assert property ((s_rd and (!divisor_latch_access_bit_r && (address == LP_DIV_LO_OFS ||
    address == LP_DIV_HI_OFS))) |-> readdata == 32'h0) else $error("Lock.");
  chk_pulse_one: assert property (lp_pulse |=> !lp_pulse) else $error("Pulse.");
  chk_pulse_src: assert property (lp_pulse |-> $past(sir_in, 3) || $past(sir_in, 4) ||
    $past(sir_in, 5) || $past(sir_in, 6)) else $error("Source.");
  chk_idle_off: assert property (!lp_clk_on [*8] |-> !lp_pulse) else $error("Idle.");
  chk_stat_clk: assert property ((s_rd and (address == STATUS_OFS)) |->
    readdata[0] == $past(lp_clk_on)) else $error("Status.");
endmodule
bind ulp_top ulp_monitor i_mon (.clk(clk), .nrst(nrst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest),
  .sir_in(sir_in), .lp_pulse(lp_pulse), .lp_clk_on(lp_clk_on));
`default_nettype wire

//--- tb/ulp_sir_model.sv
`timescale 1ns/10ps
`default_nettype none
module ulp_sir_model
(
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [15:0] len,
  output var  logic        sir_in
);
  logic [15:0] cnt_r = 16'h0000;
  always_ff @(posedge clk)
    if (fire)
      cnt_r <= len;
    else if (cnt_r != 16'h0000)
      cnt_r <= cnt_r - 16'h0001;
  assign sir_in = cnt_r != 16'h0000;
endmodule
`default_nettype wire
